//--- src/ssr_pkg.sv
// Package: shared constants and types of the status reporting block
package ssr_pkg;

    // ------------------------------------------------------------
    // Status byte bit positions
    // ------------------------------------------------------------
    localparam int STB_OPR = 7;
    localparam int STB_RQS = 6;
    localparam int STB_ESB = 5;
    localparam int STB_MAV = 4;
    localparam int STB_WAR = 1;

    // ------------------------------------------------------------
    // Standard event bit positions
    // ------------------------------------------------------------
    localparam int SEF_PON = 7;
    localparam int SEF_CME = 5;
    localparam int SEF_EXE = 4;
    localparam int SEF_QYE = 2;
    localparam int SEF_OPC = 0;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SRE_VALID_MASK = 8'hB2;  // Bits 7,5,4,1 only; largest value 178
    localparam logic [7:0] SEF_USED_MASK = 8'hB5;   // Bits 6,3,1 always zero
    localparam logic [7:0] SEF_PON_RESET = 8'h80;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Event strobes from the command processor
    // ------------------------------------------------------------
    typedef struct packed {
        logic syntax_err;    // Program message syntax error
        logic exec_err;      // Out of range or conflicting settings
        logic query_err;     // Empty read or lost response
        logic op_complete;   // Pending OPC work finished
    } ssr_events_t;

    // Host accesses, one-cycle strobes
    typedef struct packed {
        logic serial_poll;   // Serial poll performed
        logic stb_query;     // Status byte query
        logic esr_query;     // Standard event query
        logic clear_status;  // Clear-status command
        logic sre_write;     // Load service request enable
        logic ese_write;     // Load standard event enable
    } ssr_host_t;

endpackage : ssr_pkg

//--- src/ssr_trans_filter.sv
// Transition filter and latched event register for condition bits
`timescale 1ns/1ps
`default_nettype none
module ssr_trans_filter #(
    parameter int WIDTH = 16
) (
    input wire logic clk,                 // Core clock
    input wire logic rst_n,               // Synchronous reset, active low
    input wire logic [WIDTH-1:0] cond,    // Condition bits
    input wire logic [WIDTH-1:0] ptr,     // Rising edge filter
    input wire logic [WIDTH-1:0] ntr,     // Falling edge filter
    input wire logic clear,               // Read or clear-status
    output logic [WIDTH-1:0] events       // Latched event bits
);
    import ssr_pkg::*;

    initial begin
        if (WIDTH < 1) $error("ssr_trans_filter: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] cond_q, cond_d;
    logic [WIDTH-1:0] evt_q, evt_d;

    // ------------------------------------------------------------
    // Per-bit edge detect and latch
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic hit;
            // Both filters zero gives no hit at all
            assign hit = (ptr[i] & ~cond_q[i] & cond[i])       // RULE17
                       | (ntr[i] & cond_q[i] & ~cond[i]);      // RULE16 RULE18
            // A hit in the clear cycle survives the clear
            assign evt_d[i] = hit | (evt_q[i] & ~clear);       // RULE20
        end
    endgenerate

    always_comb begin
        cond_d = cond;
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cond_q <= cond_d;  // Track the pins so release brings no false edge
            evt_q <= '0;
        end else begin
            cond_q <= cond_d;
            evt_q <= evt_d;
        end
    end

    assign events = evt_q;

endmodule : ssr_trans_filter
`default_nettype wire

//--- src/ssr_mask_summary.sv
// Masked OR summary of an event byte
`timescale 1ns/1ps
`default_nettype none
module ssr_mask_summary #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] bits,    // Event bits
    input wire logic [WIDTH-1:0] enable,  // Enable mask
    output logic summary                  // OR of enabled bits
);
    import ssr_pkg::*;

    initial begin
        if (WIDTH < 1) $error("ssr_mask_summary: WIDTH must be at least 1");
    end

    // AND each bit with its enable, then OR all
    assign summary = |(bits & enable);

endmodule : ssr_mask_summary
`default_nettype wire

//--- src/ssr_status_core.sv
// Status byte, standard event register and service request of the status system
//
// Notes on behaviour
// RULE1: Enabled status byte bits ORed raise request.
// RULE2: Status byte returned on poll and query.
// RULE3: Poll bit 6 is request, cleared by poll.
// RULE4: Query bit 6 is summary, not read-cleared.
// RULE5: Bit 5 set while enabled event present.
// RULE6: Bit 4 follows output queue not empty.
// RULE7: Host polls for bit 4 around queries.
// RULE8: Event bits gated by enables form bit 5.
// RULE9: Event register cleared by read, clear, power-up.
// RULE10: Power-on bit set at power-up only.
// RULE11: Event bits 6, 3, 1 read zero.
// RULE12: Syntax error sets bit 5.
// RULE13: Range or conflict error sets bit 4.
// RULE14: Empty read or lost data sets bit 2.
// RULE15: Operation complete sets bit 0.
// RULE16: Falling filter catches falling condition.
// RULE17: Rising filter catches rising condition.
// RULE18: No filter, no event.
// RULE19: Bit 7 operation, bit 1 warning summaries.
// RULE20: Operation events latched until read or clear.
// RULE21: Clear-status clears event registers and status byte.
// RULE22: Enables limited to 178 and 255.
`timescale 1ns/1ps
`default_nettype none
module ssr_status_core #(
    parameter int OPER_WIDTH = 16,
    parameter int WARN_WIDTH = 16
) (
    input wire logic CORE_CLK,                        // 250 MHz core clock
    input wire logic RESETN,                          // Power-on reset, active low
    input wire ssr_pkg::ssr_host_t HOST_ACC,          // Host access strobes
    input wire logic [7:0] HOST_WDATA,                // Enable mask value
    input wire ssr_pkg::ssr_events_t EVENTS,          // Event strobes
    input wire logic OUT_QUEUE_NONEMPTY,              // Response waiting in queue
    input wire logic [OPER_WIDTH-1:0] OPER_COND,      // Operation condition bits
    input wire logic [OPER_WIDTH-1:0] OPER_PTR,       // Operation rising filter
    input wire logic [OPER_WIDTH-1:0] OPER_NTR,       // Operation falling filter
    input wire logic [OPER_WIDTH-1:0] OPER_ENABLE,    // Operation event enable
    input wire logic OPER_READ,                       // Operation event read
    input wire logic [WARN_WIDTH-1:0] WARN_EVENTS,    // Warning event strobes
    input wire logic [WARN_WIDTH-1:0] WARN_ENABLE,    // Warning event enable
    input wire logic WARN_READ,                       // Warning event read
    output logic [7:0] STB_POLL_DATA,                 // Status byte for serial poll
    output logic [7:0] STB_QUERY_DATA,                // Status byte for query
    output logic [7:0] ESR_DATA,                      // Standard event value
    output logic [7:0] SRE_VALUE,                     // Service request enable
    output logic [7:0] ESE_VALUE,                     // Standard event enable
    output logic [OPER_WIDTH-1:0] OPER_EVENTS,        // Operation events
    output logic [WARN_WIDTH-1:0] WARN_EVENT_REG,     // Warning events
    output logic SRQ                                  // Service request
);
    import ssr_pkg::*;

    initial begin
        if (OPER_WIDTH < 1 || WARN_WIDTH < 1) $error("ssr_status_core: widths must be at least 1");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] sef_q, sef_d;          // Standard event flags
    logic [7:0] sre_q, sre_d;          // Service request enable
    logic [7:0] ese_q, ese_d;          // Standard event enable
    logic [WARN_WIDTH-1:0] warn_q, warn_d;
    logic rqs_q, rqs_d;                // Request flag for serial poll
    logic mss_prev_q, mss_prev_d;      // Summary of previous cycle
    logic [7:0] poll_q, poll_d;
    logic [7:0] query_q, query_d;
    logic [7:0] esr_q, esr_d;
    logic srq_q, srq_d;

    logic [OPER_WIDTH-1:0] oper_evt;
    logic oper_sum, warn_sum, esb_sum, mss;
    logic [7:0] stb_base;
    logic oper_clear;

    // ------------------------------------------------------------
    // Operation group through transition filters
    // ------------------------------------------------------------
    assign oper_clear = OPER_READ | HOST_ACC.clear_status;  // RULE21

    ssr_trans_filter #(
        .WIDTH(OPER_WIDTH)
    ) u_oper (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .cond(OPER_COND),
        .ptr(OPER_PTR),
        .ntr(OPER_NTR),
        .clear(oper_clear),
        .events(oper_evt)
    );

    // ------------------------------------------------------------
    // Summaries
    // ------------------------------------------------------------
    ssr_mask_summary #(.WIDTH(OPER_WIDTH)) u_oper_sum (
        .bits(oper_evt),
        .enable(OPER_ENABLE),
        .summary(oper_sum)                                   // RULE19
    );

    ssr_mask_summary #(.WIDTH(WARN_WIDTH)) u_warn_sum (
        .bits(warn_q),
        .enable(WARN_ENABLE),
        .summary(warn_sum)                                   // RULE19
    );

    ssr_mask_summary #(.WIDTH(8)) u_esb_sum (
        .bits(sef_q),
        .enable(ese_q),
        .summary(esb_sum)                                    // RULE8 RULE5
    );

    // Status byte without bit 6; unused bits 3, 2, 0 stay zero
    always_comb begin
        stb_base = BYTE_ZERO;
        stb_base[STB_OPR] = oper_sum;                        // RULE19
        stb_base[STB_ESB] = esb_sum;                         // RULE5
        stb_base[STB_MAV] = OUT_QUEUE_NONEMPTY;              // RULE6
        stb_base[STB_WAR] = warn_sum;                        // RULE19
    end

    // Master summary from enabled status byte bits
    ssr_mask_summary #(.WIDTH(8)) u_mss (
        .bits(stb_base),
        .enable(sre_q),
        .summary(mss)                                        // RULE1
    );

    // ------------------------------------------------------------
    // Standard event flags and warning events
    // ------------------------------------------------------------
    // A new event in the read cycle is kept, so nothing is lost
    always_comb begin
        logic [7:0] sets;
        logic clr;
        sets = BYTE_ZERO;
        clr = HOST_ACC.esr_query | HOST_ACC.clear_status;    // RULE9 RULE21
        sets[SEF_CME] = EVENTS.syntax_err;                   // RULE12
        sets[SEF_EXE] = EVENTS.exec_err;                     // RULE13
        sets[SEF_QYE] = EVENTS.query_err;                    // RULE14
        sets[SEF_OPC] = EVENTS.op_complete;                  // RULE15
        // Power-on bit has no set source after reset
        sef_d = ((clr ? BYTE_ZERO : sef_q) | sets) & SEF_USED_MASK;  // RULE10 RULE11
        warn_d = (WARN_READ | HOST_ACC.clear_status) ? WARN_EVENTS : (warn_q | WARN_EVENTS);  // RULE21
    end

    // ------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------
    // Disallowed bits of the request mask are dropped on write
    always_comb begin
        sre_d = sre_q;
        ese_d = ese_q;
        if (HOST_ACC.sre_write) sre_d = HOST_WDATA & SRE_VALID_MASK;  // RULE22
        if (HOST_ACC.ese_write) ese_d = HOST_WDATA;                   // RULE22
    end

    // ------------------------------------------------------------
    // Request flag and output byte images
    // ------------------------------------------------------------
    // Request is raised on a rising summary; a poll clears it but a
    // fresh rise in the same cycle wins
    always_comb begin
        mss_prev_d = mss;
        rqs_d = rqs_q;
        if (HOST_ACC.serial_poll || HOST_ACC.clear_status) rqs_d = 1'b0;  // RULE3 RULE21
        if (mss && !mss_prev_q) rqs_d = 1'b1;                             // RULE1
        if (!mss) rqs_d = 1'b0;
        poll_d = stb_base;
        poll_d[STB_RQS] = rqs_q;                                          // RULE3 RULE2
        query_d = stb_base;
        query_d[STB_RQS] = mss;                                           // RULE4 RULE2
        esr_d = sef_q;                                                    // RULE9
        srq_d = rqs_d;                                                    // RULE1
    end

    // Registers only; power-up leaves the power-on bit set
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            sef_q <= SEF_PON_RESET;                          // RULE10 RULE9
            sre_q <= BYTE_ZERO;
            ese_q <= BYTE_ZERO;
            warn_q <= '0;
            rqs_q <= 1'b0;
            mss_prev_q <= 1'b0;
            poll_q <= BYTE_ZERO;
            query_q <= BYTE_ZERO;
            esr_q <= BYTE_ZERO;
            srq_q <= 1'b0;
        end else begin
            sef_q <= sef_d;
            sre_q <= sre_d;
            ese_q <= ese_d;
            warn_q <= warn_d;
            rqs_q <= rqs_d;
            mss_prev_q <= mss_prev_d;
            poll_q <= poll_d;
            query_q <= query_d;
            esr_q <= esr_d;
            srq_q <= srq_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign STB_POLL_DATA = poll_q;
    assign STB_QUERY_DATA = query_q;
    assign ESR_DATA = esr_q;
    assign SRE_VALUE = sre_q;
    assign ESE_VALUE = ese_q;
    assign OPER_EVENTS = oper_evt;
    assign WARN_EVENT_REG = warn_q;
    assign SRQ = srq_q;

endmodule : ssr_status_core
`default_nettype wire

//--- test/ssr_status_chk.sv
// Port checker of the status reporting block
`timescale 1ns/1ps
`default_nettype none
module ssr_status_chk (
    input wire logic CORE_CLK, // Core clock
    input wire logic RESETN, // Reset, active low
    input wire ssr_pkg::ssr_host_t HOST_ACC, // Host strobes
    input wire ssr_pkg::ssr_events_t EVENTS, // Event strobes
    input wire logic [7:0] STB_POLL_DATA, // Poll image
    input wire logic [7:0] STB_QUERY_DATA, // Query image
    input wire logic [7:0] ESR_DATA, // Standard events
    input wire logic [7:0] SRE_VALUE, // Request enable
    input wire logic [7:0] ESE_VALUE, // Event enable
    input wire logic SRQ // Service request
);
    import ssr_pkg::*;
    // Images lag state, so summaries are judged only once inputs sat still
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    chk_unused_zero: assert property ((ESR_DATA & ~SEF_USED_MASK) == BYTE_ZERO)
        else $error("unused event bit set");
    chk_stb_spare: assert property ((STB_QUERY_DATA & 8'h0D) == 8'h00 && (STB_POLL_DATA & 8'h0D) == 8'h00)
        else $error("spare status bit set");
    chk_sre_range: assert property ((SRE_VALUE & ~SRE_VALID_MASK) == BYTE_ZERO)
        else $error("request enable out of range");
    chk_exe_sets: assert property (EVENTS.exec_err |-> ##2 ESR_DATA[SEF_EXE])
        else $error("execution error not latched");
    chk_cme_sets: assert property (EVENTS.syntax_err |-> ##2 ESR_DATA[SEF_CME])
        else $error("syntax error not latched");
    chk_esr_clears: assert property ((HOST_ACC.esr_query || HOST_ACC.clear_status) && EVENTS == 4'h0 |-> ##2 ESR_DATA == BYTE_ZERO)
        else $error("event register not cleared");
    chk_esb_sum: assert property (($stable(ESR_DATA) && $stable(ESE_VALUE)) [*3] |-> STB_QUERY_DATA[STB_ESB] == |(ESR_DATA & ESE_VALUE))
        else $error("event summary wrong");
    chk_mss_sum: assert property (($stable(STB_QUERY_DATA) && $stable(SRE_VALUE)) [*3] |-> STB_QUERY_DATA[STB_RQS] == |(STB_QUERY_DATA & SRE_VALUE & 8'hBF))
        else $error("master summary wrong");
    chk_srq_rise: assert property ($rose(SRQ) |-> STB_QUERY_DATA[STB_RQS])
        else $error("request without summary");
    chk_poll_clears: assert property (HOST_ACC.serial_poll && SRQ |=> !SRQ || $rose(STB_QUERY_DATA[STB_RQS]))
        else $error("poll left request set");
endmodule : ssr_status_chk
bind ssr_status_core ssr_status_chk ssr_status_chk_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HOST_ACC(HOST_ACC),
    .EVENTS(EVENTS), .STB_POLL_DATA(STB_POLL_DATA), .STB_QUERY_DATA(STB_QUERY_DATA), .ESR_DATA(ESR_DATA),
    .SRE_VALUE(SRE_VALUE), .ESE_VALUE(ESE_VALUE), .SRQ(SRQ));
`default_nettype wire

//--- test/ssr_host_model.sv
// Remote host model issuing strobes, polls and queries
`timescale 1ns/1ps
`default_nettype none
module ssr_host_model (
    input wire logic clk, // Core clock
    output var ssr_pkg::ssr_host_t acc, // Host strobes
    output var logic [7:0] wdata, // Mask value
    input wire logic [7:0] poll_d, // Poll image
    input wire logic [7:0] query_d, // Query image
    input wire logic [7:0] esr_d // Event image
);
    import ssr_pkg::*;
    // Idle strobes, data line scrambled while unused
    initial begin
        acc = '0;
        wdata = 8'hA5;
    end
    // One strobe cycle; answer taken at the edge that takes it
    task automatic op(input ssr_host_t a, input logic [7:0] d, output logic [7:0] ans);
        @(posedge clk);
        acc <= a;
        wdata <= d;
        @(posedge clk);
        ans = a.serial_poll ? poll_d : a.esr_query ? esr_d : query_d;
        acc <= '0;
        wdata <= ~d;
    endtask : op
    // Poll until the message bit reaches the wanted level, bounded
    task automatic mav(input logic lvl, output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            op(6'h20, 8'h00, s);
            ok = (s[STB_MAV] === lvl);
        end
    endtask : mav
endmodule : ssr_host_model
`default_nettype wire

//--- test/tb_status_reporting_summary.sv
// Self-checking bench of the status reporting block
`timescale 1ns/1ps
`default_nettype none
module tb_status_reporting_summary;
    import ssr_pkg::*;
    localparam ssr_host_t POLL = 6'h20;
    localparam ssr_host_t STBQ = 6'h10;
    localparam ssr_host_t ESRQ = 6'h08;
    localparam ssr_host_t CLS = 6'h04;
    localparam ssr_host_t SREW = 6'h02;
    localparam ssr_host_t ESEW = 6'h01;
    logic clk, rst_n, mav_in, oread, wread, srq;
    ssr_host_t acc;
    ssr_events_t ev;
    logic [7:0] wd, poll_d, query_d, esr_d, sre_v, ese_v;
    logic [15:0] cond, ptr, ntr, oen, wev, wen, oev, wreg;
    int n_errors;
    int num_checks;
    ssr_status_core ssr_status_core_i (.CORE_CLK(clk), .RESETN(rst_n), .HOST_ACC(acc), .HOST_WDATA(wd),
        .EVENTS(ev), .OUT_QUEUE_NONEMPTY(mav_in), .OPER_COND(cond), .OPER_PTR(ptr), .OPER_NTR(ntr),
        .OPER_ENABLE(oen), .OPER_READ(oread), .WARN_EVENTS(wev), .WARN_ENABLE(wen), .WARN_READ(wread),
        .STB_POLL_DATA(poll_d), .STB_QUERY_DATA(query_d), .ESR_DATA(esr_d), .SRE_VALUE(sre_v),
        .ESE_VALUE(ese_v), .OPER_EVENTS(oev), .WARN_EVENT_REG(wreg), .SRQ(srq));
    ssr_host_model ssr_host_model_i (.clk(clk), .acc(acc), .wdata(wd), .poll_d(poll_d), .query_d(query_d),
        .esr_d(esr_d));
    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Automatic, since the watchdog and the main sequence wait at once
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // Summary bits given; request summary fills bit 6
    function automatic logic [7:0] exp_stb(input logic [7:0] sum, input logic [7:0] sre);
        exp_stb = sum | {1'b0, |(sum & sre), 6'h00};
    endfunction : exp_stb
    function automatic logic [7:0] ev_byte(input ssr_events_t e);
        ev_byte = {2'b00, e.syntax_err, e.exec_err, 1'b0, e.query_err, 1'b0, e.op_complete};
    endfunction : ev_byte
    task pulse(input ssr_events_t e);
        ev <= e;
        tick(1);
        ev <= '0;
        tick(3);
    endtask : pulse
    // Watchdog sized well beyond the sequence length
    initial begin
        tick(20000);
        n_errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        logic [7:0] r, a;
        logic [15:0] e, p, c;
        ssr_events_t x;
        logic ok;
        void'($urandom(32'hBFA1));
        {rst_n, mav_in, oread, wread, ev, cond, ptr, ntr, oen, wev, wen} = '0;
        tick(4);
        rst_n <= 1'b1;
        tick(2);
        ssr_host_model_i.op(ESRQ, 8'h00, r);
        chk8("pon", 8'h80, r);
        ssr_host_model_i.op(ESRQ, 8'h00, r);
        chk8("pon gone", 8'h00, r);
        // Each event alone, then random mixes
        for (int i = 0; i < 12; i++) begin
            x = (i < 4) ? ssr_events_t'(4'h8 >> i) : ssr_events_t'($urandom);
            pulse(x);
            ssr_host_model_i.op(ESRQ, 8'h00, r);
            chk8("events", ev_byte(x), r);
        end
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 8'hFF : 8'($urandom);
            ssr_host_model_i.op(SREW, r, a);
            ssr_host_model_i.op(ESEW, ~r, a);
            tick(1);
            chk8("sre", r & SRE_VALID_MASK, sre_v);
            chk8("ese", ~r, ese_v);
        end
        ssr_host_model_i.op(ESEW, 8'h10, a);
        ssr_host_model_i.op(SREW, 8'h20, a);
        pulse(4'h4);
        ssr_host_model_i.op(STBQ, 8'h00, r);
        chk8("stb", exp_stb(8'h20, 8'h20), r);
        chk8("srq", 8'h01, {7'h00, srq});
        ssr_host_model_i.op(POLL, 8'h00, r);
        chk8("poll", 8'h60, r);
        tick(2);
        ssr_host_model_i.op(POLL, 8'h00, r);
        chk8("poll after", 8'h20, r);
        chk8("srq polled", 8'h00, {7'h00, srq});
        ssr_host_model_i.op(STBQ, 8'h00, r);
        chk8("stb kept", 8'h60, r);
        ssr_host_model_i.op(ESRQ, 8'h00, r);
        tick(3);
        ssr_host_model_i.op(STBQ, 8'h00, r);
        chk8("stb clear", 8'h00, r);
        mav_in <= 1'b1;
        ssr_host_model_i.mav(1'b1, ok);
        chk8("mav set", 8'h01, {7'h00, ok});
        mav_in <= 1'b0;
        ssr_host_model_i.mav(1'b0, ok);
        chk8("mav clear", 8'h01, {7'h00, ok});
        pulse(4'h8);
        ssr_host_model_i.op(CLS, 8'h00, a);
        tick(3);
        ssr_host_model_i.op(ESRQ, 8'h00, r);
        chk8("cls", 8'h00, r);
        // Rising only, falling only, no filter, random filters
        for (int k = 0; k < 4; k++) begin
            ptr <= (k == 0) ? 16'hFFFF : (k == 3) ? 16'($urandom) : 16'h0000;
            ntr <= (k == 1) ? 16'hFFFF : (k == 3) ? 16'($urandom) : 16'h0000;
            oread <= 1'b1;
            tick(1);
            oread <= 1'b0;
            tick(2);
            c = cond;
            e = '0;
            for (int i = 0; i < 8; i++) begin
                p = c;
                c = 16'($urandom);
                cond <= c;
                e = e | (c & ~p & ptr) | (~c & p & ntr);
                tick(1);
            end
            tick(3);
            chk16("oper", e, oev);
        end
        oen <= 16'hFFFF;
        wen <= 16'h0004;
        wev <= 16'h0004;
        tick(1);
        wev <= '0;
        tick(3);
        chk16("warn", 16'h0004, wreg);
        ssr_host_model_i.op(STBQ, 8'h00, r);
        chk8("stb sums", exp_stb({|e, 5'h00, 2'b10}, 8'h20), r);
        oread <= 1'b1;
        wread <= 1'b1;
        tick(1);
        {oread, wread} <= 2'b00;
        tick(3);
        ssr_host_model_i.op(STBQ, 8'h00, r);
        chk8("stb read", 8'h00, r);
        // Second power-up in mid-run, conditions and filters left as they are
        rst_n <= 1'b0;
        tick(4);
        rst_n <= 1'b1;
        tick(2);
        ssr_host_model_i.op(ESRQ, 8'h00, r);
        chk8("pon again", 8'h80, r);
        chk16("oper after reset", 16'h0000, oev);
        stop_test();
    end
endmodule : tb_status_reporting_summary
`default_nettype wire
